// file: divider_pkg.sv
// Summary of operation
// - One output period completes for every selected-modulus input clock cycles.
// - Even modulus gives equal high and low halves of modulus/2 cycles each.
// - Odd modulus holds one level an extra cycle; modulus 11 gives 6 high, 5 low.
// - Modulus-extend input switches dual mode between base and base plus one.
// - Semi-fixed mode selects among 32, 64 and 128, not one apart.
// - Four-ratio mode selects 128, 144, 256 or 272.
// - Output changes only on input clock edges, once per half-modulus cycles.
// - Optional fixed divide-by-two configuration.
// - Extended 64/65 mode stretches low half to 33, high stays 32.
package divider_pkg;

  // ------------------------------------------------------------
  // Sizes and defaults
  // ------------------------------------------------------------
  localparam int unsigned DEF_CNT_W = 9;
  localparam int unsigned DEF_BASE_DIVISOR = 64;
  localparam logic START_LEVEL = 1'b1;

  // ------------------------------------------------------------
  // Modulus tables
  // ------------------------------------------------------------
  localparam int unsigned SEMI_MOD_0 = 32;
  localparam int unsigned SEMI_MOD_1 = 64;
  localparam int unsigned SEMI_MOD_2 = 128;
  localparam int unsigned QUAD_MOD_0 = 128;
  localparam int unsigned QUAD_MOD_1 = 144;
  localparam int unsigned QUAD_MOD_2 = 256;
  localparam int unsigned QUAD_MOD_3 = 272;
  localparam int unsigned FIX2_MOD = 2;
  localparam int unsigned MAX_MOD = 272;

  // ------------------------------------------------------------
  // Mode pin codes and internal one-hot modes
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_CODE_DUAL = 2'h0;
  localparam logic [1:0] MODE_CODE_SEMI = 2'h1;
  localparam logic [1:0] MODE_CODE_QUAD = 2'h2;
  localparam logic [1:0] MODE_CODE_FIX2 = 2'h3;

  localparam logic [1:0] RATIO_0 = 2'h0;
  localparam logic [1:0] RATIO_1 = 2'h1;
  localparam logic [1:0] RATIO_2 = 2'h2;
  localparam logic [1:0] RATIO_3 = 2'h3;

  typedef enum logic [3:0] {
    MODE_DUAL = 4'h1,
    MODE_SEMI = 4'h2,
    MODE_QUAD = 4'h4,
    MODE_FIX2 = 4'h8
  } mode_type;

endpackage

// file: div_ctrl_if.sv
`timescale 1ns/1ps
// Load and terminal-count handshake between the sequencer and its counter
interface div_ctrl_if #(parameter int unsigned CNT_W = 9);
  logic load;
  logic [CNT_W-1:0] load_val;
  logic at_zero;
  modport ctrl (output load, output load_val, input at_zero);
  modport cnt (input load, input load_val, output at_zero);
endinterface

// file: half_counter.sv
`timescale 1ns/1ps
module half_counter #(
  parameter int unsigned CNT_W = 9,
  parameter logic [CNT_W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  div_ctrl_if.cnt ctl
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ------------------------------------------------------------
  // Down counter for one half period
  // ------------------------------------------------------------
  // Load wins; otherwise count down and park at zero
  always_comb begin
    cnt_d = cnt_q;
    if (ctl.load) begin
      cnt_d = ctl.load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= RST_VAL;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Terminal count; the sequencer always reloads here
  assign ctl.at_zero = (cnt_q == '0);

endmodule // half_counter

// file: dual_modulus_frequency_divider.sv
`timescale 1ns/1ps
module dual_modulus_frequency_divider #(
  parameter int unsigned CNT_W = divider_pkg::DEF_CNT_W,
  parameter int unsigned BASE_DIVISOR = divider_pkg::DEF_BASE_DIVISOR
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sync_clr,
  input wire logic [1:0] mode_code,
  input wire logic [1:0] ratio_sel,
  input wire logic modulus_ext,
  output logic div_out,
  output logic period_end,
  output logic [CNT_W-1:0] active_modulus
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Base plus one and the largest table entry must fit the counter
  generate
    if (BASE_DIVISOR < 2 || (BASE_DIVISOR + 1) >= (2 ** CNT_W) ||
        divider_pkg::MAX_MOD >= (2 ** CNT_W)) begin : g_bad_param
      $error("dual_modulus_frequency_divider: CNT_W too small or BASE_DIVISOR below 2");
    end
  endgenerate

  localparam logic [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [CNT_W-1:0] BASE_W = CNT_W'(BASE_DIVISOR);
  localparam logic [CNT_W-1:0] RST_HI = CNT_W'((BASE_DIVISOR + 1) / 2);
  localparam logic [CNT_W-1:0] RST_LO = CNT_W'(BASE_DIVISOR - (BASE_DIVISOR + 1) / 2);

  // ------------------------------------------------------------
  // Modulus selection
  // ------------------------------------------------------------
  divider_pkg::mode_type mode;
  logic [CNT_W-1:0] base_m;
  logic ext;
  logic [CNT_W:0] round_up;
  logic [CNT_W-1:0] hi_new;
  logic [CNT_W-1:0] lo_new;

  // Pin code to one-hot mode
  always_comb begin
    unique case (mode_code)
      divider_pkg::MODE_CODE_DUAL: mode = divider_pkg::MODE_DUAL;
      divider_pkg::MODE_CODE_SEMI: mode = divider_pkg::MODE_SEMI;
      divider_pkg::MODE_CODE_QUAD: mode = divider_pkg::MODE_QUAD;
      divider_pkg::MODE_CODE_FIX2: mode = divider_pkg::MODE_FIX2;
    endcase
  end

  // Unextended modulus and extension bit for each mode
  always_comb begin
    base_m = BASE_W;
    ext = 1'b0;
    unique case (mode)
      divider_pkg::MODE_DUAL: begin
        base_m = BASE_W;
        ext = modulus_ext;
      end
      divider_pkg::MODE_SEMI: begin
        // Semi-fixed set; the spare code falls back to the base divisor
        unique case (ratio_sel)
          divider_pkg::RATIO_0: base_m = CNT_W'(divider_pkg::SEMI_MOD_0);
          divider_pkg::RATIO_1: base_m = CNT_W'(divider_pkg::SEMI_MOD_1);
          divider_pkg::RATIO_2: base_m = CNT_W'(divider_pkg::SEMI_MOD_2);
          divider_pkg::RATIO_3: base_m = BASE_W;
        endcase
      end
      divider_pkg::MODE_QUAD: begin
        unique case (ratio_sel)
          divider_pkg::RATIO_0: base_m = CNT_W'(divider_pkg::QUAD_MOD_0);
          divider_pkg::RATIO_1: base_m = CNT_W'(divider_pkg::QUAD_MOD_1);
          divider_pkg::RATIO_2: base_m = CNT_W'(divider_pkg::QUAD_MOD_2);
          divider_pkg::RATIO_3: base_m = CNT_W'(divider_pkg::QUAD_MOD_3);
        endcase
      end
      divider_pkg::MODE_FIX2: begin
        base_m = CNT_W'(divider_pkg::FIX2_MOD);
      end
    endcase
  end

  // High half is the rounded-up half of the unextended modulus, so an odd
  // modulus puts its extra cycle high, while the extension cycle always
  // lands in the low half
  always_comb begin
    round_up = {1'b0, base_m} + {{CNT_W{1'b0}}, 1'b1};
    hi_new = round_up[CNT_W:1];
    lo_new = base_m + {{(CNT_W-1){1'b0}}, ext} - hi_new;
  end

  // ------------------------------------------------------------
  // Half-period counter
  // ------------------------------------------------------------
  div_ctrl_if #(.CNT_W(CNT_W)) ctl_if ();

  half_counter #(
    .CNT_W(CNT_W),
    .RST_VAL(RST_HI - ONE)
  ) u_half_counter (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ctl(ctl_if.cnt)
  );

  // ------------------------------------------------------------
  // Output sequencer
  // ------------------------------------------------------------
  logic level_q;
  logic level_d;
  logic [CNT_W-1:0] lo_len_q;
  logic [CNT_W-1:0] lo_len_d;
  logic done_q;
  logic done_d;
  logic [CNT_W-1:0] mod_q;
  logic [CNT_W-1:0] mod_d;

  // Lengths are taken only at the low-to-high boundary or on a clear; the low length is
  // held so a mid-period change of the inputs cannot shorten the period
  always_comb begin
    level_d = level_q;
    lo_len_d = lo_len_q;
    done_d = 1'b0;
    mod_d = mod_q;
    ctl_if.load = 1'b0;
    ctl_if.load_val = hi_new - ONE;
    if (sync_clr) begin
      level_d = divider_pkg::START_LEVEL;
      ctl_if.load = 1'b1;
      lo_len_d = lo_new;
      mod_d = hi_new + lo_new;
    end else if (ctl_if.at_zero) begin
      ctl_if.load = 1'b1;
      if (level_q) begin
        level_d = 1'b0;
        ctl_if.load_val = lo_len_q - ONE;
      end else begin
        level_d = 1'b1;
        lo_len_d = lo_new;
        mod_d = hi_new + lo_new;
        done_d = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= divider_pkg::START_LEVEL;
      lo_len_q <= RST_LO;
      done_q <= 1'b0;
      mod_q <= BASE_W;
    end else begin
      level_q <= level_d;
      lo_len_q <= lo_len_d;
      done_q <= done_d;
      mod_q <= mod_d;
    end
  end

  // Every output is a flip-flop so the divided clock is glitch free
  assign div_out = level_q;
  assign period_end = done_q;
  assign active_modulus = mod_q;

endmodule // dual_modulus_frequency_divider

// file: divider_monitor.sv
`timescale 1ns/1ps
// ----
// Port checker
// ----
module divider_monitor #(
  parameter int unsigned CNT_W = 9,
  parameter int unsigned BASE_DIVISOR = 64
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sync_clr,
  input wire logic [1:0] mode_code,
  input wire logic [1:0] ratio_sel,
  input wire logic modulus_ext,
  input wire logic div_out,
  input wire logic period_end,
  input wire logic [CNT_W-1:0] active_modulus
);
  logic lvl_q;
  logic clr_q;
  logic seen_q;
  logic [CNT_W-1:0] run_q;
  logic [CNT_W-1:0] hi_exp;
  // Extension cycle lives in the low half, so high keeps the base length
  assign hi_exp = (active_modulus == CNT_W'(BASE_DIVISOR + 1)) ?
    CNT_W'(BASE_DIVISOR - BASE_DIVISOR / 2) : active_modulus - active_modulus / 2;
  // Level run length; a clear restarts it, first period after reset is skipped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 1'b1;
      clr_q <= 1'b0;
      seen_q <= 1'b0;
      run_q <= '0;
    end else begin
      lvl_q <= div_out;
      clr_q <= sync_clr;
      seen_q <= seen_q | period_end;
      run_q <= (clr_q || div_out != lvl_q) ? CNT_W'(1) : run_q + 1'b1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_end_on_rise: assert property ($rose(div_out) && !clr_q |-> period_end)
    else $error("no period end on rise");
  a_end_only_rise: assert property (period_end |-> $rose(div_out))
    else $error("stray period end");
  a_mod_hold: assert property (!period_end && !clr_q |-> $stable(active_modulus))
    else $error("modulus changed mid period");
  a_high_len: assert property (seen_q && $fell(div_out) |-> run_q == hi_exp)
    else $error("high half length wrong");
  a_low_len: assert property (seen_q && $rose(div_out) && !clr_q
    |-> run_q == $past(active_modulus) - $past(hi_exp)) else $error("low half length wrong");
  a_no_double_toggle: assert property ($changed(div_out) && active_modulus > 3
    && !sync_clr |=> $stable(div_out)) else $error("half shorter than two cycles");
  a_fix2_toggle: assert property (active_modulus == 2 && !sync_clr |=> $changed(div_out))
    else $error("divide by two did not toggle");
  a_dual_take: assert property (period_end && !clr_q && $past(mode_code) == 2'h0
    |-> active_modulus == BASE_DIVISOR + $past(modulus_ext)) else $error("dual modulus wrong");
endmodule // divider_monitor

bind dual_modulus_frequency_divider divider_monitor #(.CNT_W(CNT_W),
  .BASE_DIVISOR(BASE_DIVISOR)) u_divider_monitor (.sys_clk, .arst_n, .sync_clr, .mode_code,
  .ratio_sel, .modulus_ext, .div_out, .period_end, .active_modulus);

// file: period_sink.sv
`timescale 1ns/1ps
// ----
// Half-length meter that samples the divided clock on the input clock
// ----
module period_sink (
  input wire logic sys_clk,
  input wire logic div_out,
  output int hi_len,
  output int lo_len
);
  int run = 0;
  logic lvl = 1'b1;
  // Measures each half in input cycles; a half is published only once it ends
  always @(posedge sys_clk) begin
    if (div_out === lvl) begin
      run++;
    end else begin
      if (lvl) hi_len = run;
      else lo_len = run;
      lvl = div_out;
      run = 1;
    end
  end
endmodule // period_sink

// file: dual_modulus_frequency_divider_bench.sv
`timescale 1ns/1ps
module dual_modulus_frequency_divider_bench;
  logic sys_clk = 0, arst_n = 0, sync_clr = 0, modulus_ext = 0, div_out, period_end, div_odd;
  logic [1:0] mode_code = 0, ratio_sel = 0;
  logic [8:0] active_modulus;
  int hi_len, lo_len, hi_odd, lo_odd, mismatches = 0, cmp_count = 0, cyc = 0, n;
  dual_modulus_frequency_divider u_dual_modulus_frequency_divider (.sys_clk, .arst_n,
    .sync_clr, .mode_code, .ratio_sel, .modulus_ext, .div_out, .period_end, .active_modulus);
  // Odd base shares every input with the main divider
  dual_modulus_frequency_divider #(.BASE_DIVISOR(11)) u_dual_modulus_frequency_divider_odd (
    .sys_clk, .arst_n, .sync_clr, .mode_code, .ratio_sel, .modulus_ext, .div_out(div_odd),
    .period_end(), .active_modulus());
  period_sink u_period_sink (.sys_clk, .div_out, .hi_len, .lo_len);
  period_sink u_period_sink_odd (.sys_clk, .div_out(div_odd), .hi_len(hi_odd), .lo_len(lo_odd));
  initial forever #25 sys_clk = ~sys_clk;
  // Whole run needs under 4000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %0d exp %0d", $time, got, exp);
    end
  endtask
  // Inputs are taken at one boundary, so the second closes a full new period
  task automatic run(input logic [1:0] m, input logic [1:0] r, input logic e);
    @(negedge sys_clk);
    mode_code = m;
    ratio_sel = r;
    modulus_ext = e;
    repeat (2) @(posedge period_end);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic t_dual();
    run(2'h0, 2'h0, 1'b0);
    chk(hi_len, 32);
    chk(lo_len, 32);
    chk(hi_odd, 6);
    chk(lo_odd, 5);
    run(2'h0, 2'h0, 1'b1);
    chk(hi_len, 32);
    chk(lo_len, 33);
    chk(active_modulus, 65);
    chk(hi_odd, 6);
    chk(lo_odd, 6);
    $display("dual done");
  endtask
  task automatic t_table(input logic [1:0] m, input int mods[4]);
    for (int i = 0; i < 4; i++) begin
      run(m, 2'(i), 1'b1);
      chk(hi_len, mods[i] / 2);
      chk(lo_len, mods[i] / 2);
      chk(active_modulus, mods[i]);
    end
    $display("table done");
  endtask
  task automatic t_fix2();
    run(2'h3, 2'h0, 1'b0);
    chk(hi_len, 1);
    chk(lo_len, 1);
    $display("fix2 done");
  endtask
  // Clear in mid low half must restart a full high half at once
  task automatic t_clear();
    run(2'h0, 2'h0, 1'b0);
    @(negedge div_out);
    repeat (5) @(negedge sys_clk);
    sync_clr = 1;
    @(negedge sys_clk);
    sync_clr = 0;
    n = 0;
    while (div_out === 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    chk(n, 32);
    $display("clear done");
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    chk(div_out, 1);
    chk(active_modulus, 64);
    arst_n = 1;
    t_dual();
    t_table(2'h1, '{32, 64, 128, 64});
    t_table(2'h2, '{128, 144, 256, 272});
    t_fix2();
    t_clear();
    summarize();
  end
endmodule // dual_modulus_frequency_divider_bench
